// ===== dv/ptd_engine_properties.sv
/* ptd_engine_properties: bus, packet link and interrupt assertions.
   Assumes it is bound to ptd_engine and sees only its ports. */
`default_nettype none
module ptd_engine_properties
    import ptd_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  reset_n,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [7:0]            wb_adr_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  irq,
    input wire logic                  pkt_req,
    input wire logic [PTD_MAXP_W-1:0] pkt_len,
    input wire logic [PTD_EP_W-1:0]   pkt_endpoint,
    input wire logic                  busy,
    input wire logic                  pkt_done,
    input wire logic                  pkt_stall,
    input wire logic                  pkt_fatal
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire logic take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    sequence s_fatal_wait;
        pkt_req ##[1:40] (pkt_fatal && busy);
    endsequence
    a_ack_one_wait: assert property (take |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_req_pulse: assert property (pkt_req |=> !pkt_req) else $error("request too long");
    a_req_busy: assert property (pkt_req |-> busy && $past(busy)) else $error("request when idle");
    a_fields_hold: assert property (!pkt_req |-> $stable({pkt_len, pkt_endpoint}))
        else $error("packet fields moved");
    a_fatal_idle: assert property (s_fatal_wait |=> !busy) else $error("fatal did not stop");
    a_stall_stop: assert property (pkt_stall && busy && !pkt_fatal |=> !busy ##1 !pkt_req)
        else $error("stall did not stop");
    a_done_next: assert property (pkt_done && busy && !pkt_stall && !pkt_fatal |=>
        !busy or (busy ##1 pkt_req)) else $error("next request misplaced");
    a_irq_masked: assert property (take && wb_we_i && wb_adr_i == PTD_REG_IRQ_MASK && wb_dat_i[2:0] == 3'h0
        |-> ##2 !irq) else $error("masked irq high");
    a_unmapped_read: assert property (take && !wb_we_i && wb_adr_i == 8'h40 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule // ptd_engine_properties
bind ptd_engine ptd_engine_properties u_props (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .pkt_req(pkt_req), .pkt_len(pkt_len), .pkt_endpoint(pkt_endpoint),
    .busy(busy), .pkt_done(pkt_done), .pkt_stall(pkt_stall), .pkt_fatal(pkt_fatal));
`default_nettype wire

// ===== dv/ptd_engine_tb.sv
/* ptd_engine_tb: runs descriptors against the link model and a bench model.
   Assumes ptd_engine, ptd_link_model and the bound checker are compiled. */
`default_nettype none
module ptd_engine_tb
    import ptd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'h0, dly = 4'h0;
    logic [1:0] mode = 2'h0;
    logic [31:0] wdat = 32'h0, rdat, seed = 32'd65839, buf_k;
    logic ack, irq, req, busy, done, stall, fatal;
    logic [10:0] len, bytes;
    logic [3:0] ep_o;
    logic [15:0] addr_o;
    logic [14:0] off_o;
    logic [2:0] uf;
    logic [11:0] exp_cnt [8];
    int failures = 0, total_checks = 0, exp_done, npk, ep, cur_maxp, cur_size;
    ptd_engine DUT (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
        .pkt_req(req), .pkt_len(len), .pkt_endpoint(ep_o), .pkt_buf_addr(addr_o), .pkt_offset(off_o),
        .busy(busy), .pkt_done(done), .pkt_bytes(bytes), .pkt_uframe(uf), .pkt_stall(stall), .pkt_fatal(fatal));
    ptd_link_model u_link (.sys_clk(sys_clk), .reset_n(reset_n), .pkt_req(req), .pkt_len(len), .mode(mode),
        .dly(dly), .pkt_done(done), .pkt_bytes(bytes), .pkt_uframe(uf), .pkt_stall(stall), .pkt_fatal(fatal));
    initial forever #20 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
        if (n >= 50) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    // bench model of one execution: packet fields, running byte count, per-microframe counts
    always @(posedge sys_clk) begin
        if (req === 1'b1) begin
            chk(32'(len), (cur_size - exp_done < cur_maxp) ? cur_size - exp_done : cur_maxp);
            chk(32'(off_o), exp_done);
            chk(32'(ep_o), ep);
            chk(32'(addr_o), buf_k);
            npk++;
        end
        if (done === 1'b1) begin
            exp_done += bytes;
            exp_cnt[uf] = 12'(bytes);
        end
    end
    task automatic run(input int mult, input int maxp, input int size, input logic [1:0] md, input logic [2:0] mask);
        logic [31:0] w, irqe;
        logic [95:0] p;
        int n, pk;
        logic vld;
        ep = rnd() % 16;
        buf_k = rnd() % 4096;
        {cur_maxp, cur_size} = {maxp, size};
        mode <= md;
        dly <= 4'(rnd() % 6);
        wr(PTD_REG_EP_HI, 32'(ep >> 1));
        wr(PTD_REG_BUF_ADDR, 32'h400 + buf_k * 8);
        w = {ep[0], mult[1:0], maxp[10:0], size[14:0], 2'b11, 1'b1};
        wr(PTD_REG_DW0, w);
        wr(PTD_REG_STATUS, 32'h0);
        {exp_done, npk} = 0;
        wr(PTD_REG_IRQ_MASK, 32'(mask));
        wr(PTD_REG_CTRL, 32'h1);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (busy !== 1'b0 && n < 3000);
        if (n >= 3000) begin
            failures++;
            stop_test();
        end
        pk = ((size + maxp - 1) / maxp < mult) ? (size + maxp - 1) / maxp : mult;
        if (md != 2'h0) pk = 1;
        chk(npk, pk);
        vld = (md == 2'h0 && exp_done < size) || md == 2'h3;
        rd_chk(PTD_REG_STATUS, {vld, md == 2'h1, 15'h0, exp_done[14:0]});
        rd_chk(PTD_REG_DW0, {w[31:3], 2'b00, vld});
        irqe = (md == 2'h0 && !vld) ? 32'h1 : (md == 2'h1) ? 32'h2 : (md == 2'h2) ? 32'h4 : 32'h0;
        rd_chk(PTD_REG_IRQ_STAT, irqe);
        chk(32'(irq), 32'(|(irqe[2:0] & mask)));
        wr(PTD_REG_IRQ_STAT, 32'h7);
        @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        for (int i = 0; i < 8; i++) p[i*12 +: 12] = exp_cnt[i];
        rd_chk(PTD_REG_INT_DW5, p[31:0]);
        rd_chk(PTD_REG_INT_DW6, p[63:32]);
        rd_chk(PTD_REG_INT_DW7, p[95:64]);
        $display("run mult %0d mode %0d finished", mult, md);
    endtask
    initial begin
        foreach (exp_cnt[i]) exp_cnt[i] = 12'h0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd_chk(PTD_REG_DW0, 32'h0);
        rd_chk(PTD_REG_STATUS, 32'h0);
        rd_chk(PTD_REG_BUF_ADDR, 32'h0);
        rd_chk(8'h40, 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        rd_chk(PTD_REG_DW0, 32'h0);
        wr(PTD_REG_DW0, 32'h0004_0009);
        wr(PTD_REG_CTRL, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(32'(busy), 32'h0);
        $display("reset and map test finished");
        for (int i = 0; i < 6; i++) run(1 + i % 3, 1 + rnd() % 1024, 1 + rnd() % 3000, 2'h0, (i % 2) ? 3'h0 : 3'h7);
        run(3, 1024, 32'h7FFF, 2'h0, 3'h7);
        run(2, 64, 128, 2'h0, 3'h7);
        run(2, 100, 500, 2'h1, 3'h7);
        run(2, 100, 500, 2'h2, 3'h7);
        run(3, 100, 500, 2'h3, 3'h7);
        stop_test();
    end
    initial begin
        #4000000;
        failures++;
        stop_test();
    end
endmodule // ptd_engine_tb
`default_nettype wire

// ===== dv/ptd_link_model.sv
/* ptd_link_model: downstream link engine answering each packet request once.
   Assumes the bench sets answer kind and delay before a descriptor starts. */
`default_nettype none
module ptd_link_model
    import ptd_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire logic                  pkt_req,
    input  wire logic [PTD_MAXP_W-1:0] pkt_len,
    input  wire logic [1:0]            mode,
    input  wire logic [3:0]            dly,
    output logic                       pkt_done,
    output logic      [PTD_MAXP_W-1:0] pkt_bytes,
    output logic      [PTD_UF_W-1:0]   pkt_uframe,
    output logic                       pkt_stall,
    output logic                       pkt_fatal
);
    int                  cnt;
    logic [PTD_MAXP_W-1:0] len_q;
    logic [PTD_UF_W-1:0]   uf;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {cnt, len_q, uf, pkt_done, pkt_bytes, pkt_uframe, pkt_stall, pkt_fatal} <= '0;
        end else begin
            {pkt_done, pkt_stall, pkt_fatal} <= 3'h0;
            pkt_bytes <= ~pkt_bytes; // byte count is meaningless outside the done pulse
            if (pkt_req) begin
                len_q <= pkt_len;
                cnt <= dly + 1;
            end else if (cnt == 1) begin
                cnt <= 0;
                pkt_done <= mode == 2'h0 || mode == 2'h3;
                pkt_stall <= mode == 2'h1;
                pkt_fatal <= mode == 2'h2;
                pkt_bytes <= (mode == 2'h3) ? len_q - 1'b1 : len_q;
                pkt_uframe <= uf;
                uf <= uf + 1'b1;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // ptd_link_model
`default_nettype wire

// ===== verilog/ptd_engine.sv
/*
 * ptd_engine: holds one periodic transfer descriptor, executes it as a series
 * of packet requests toward the link engine and writes back status.
 * Assumes a classic Wishbone master and a packet engine on the same clock
 * that answers every request with exactly one done, stall or fatal pulse.
 */
`default_nettype none
module ptd_engine
    import ptd_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         irq,
    output logic                         pkt_req,
    output logic      [PTD_MAXP_W-1:0]   pkt_len,
    output logic      [PTD_EP_W-1:0]     pkt_endpoint,
    output logic      [PTD_ADDR_W-1:0]   pkt_buf_addr,
    output logic      [PTD_SIZE_W-1:0]   pkt_offset,
    output logic                         busy,
    input  wire logic                    pkt_done,
    input  wire logic [PTD_MAXP_W-1:0]   pkt_bytes,
    input  wire logic [PTD_UF_W-1:0]     pkt_uframe,
    input  wire logic                    pkt_stall,
    input  wire logic                    pkt_fatal
);
    function automatic logic [31:0] apply_sel(input logic [31:0] old_val, input logic [31:0] new_val,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // storage
    logic [31:0]              dw0;
    logic [PTD_EPHI_W-1:0]    endpoint_high;
    logic [31:0]              buf_cpu;
    logic [PTD_SIZE_W-1:0]    bytes_done;
    logic                     halt;
    logic [PTD_IRQ_W-1:0]     irq_status;
    logic [PTD_IRQ_W-1:0]     irq_mask;
    logic [PTD_CNT_W-1:0]     rx_count [PTD_UFRAMES];
    logic [PTD_MULT_W-1:0]    pkt_count;
    ptd_state_t               state;
    ptd_state_t               next_state;

    // decoded fields
    logic [PTD_EP_W-1:0]      endpoint_number;
    logic [PTD_MULT_W-1:0]    mult;
    logic [PTD_MAXP_W-1:0]    max_packet_bytes;
    logic [PTD_SIZE_W-1:0]    transfer_size_bytes;
    logic                     valid;
    logic [31:0]              int_dw5;
    logic [31:0]              int_dw6;
    logic [31:0]              int_dw7;
    logic [PTD_UFRAMES*PTD_CNT_W-1:0] counts_flat;

    ptd_field_decode u_decode (
        .dw0                 (dw0),
        .endpoint_high       (endpoint_high),
        .endpoint_number     (endpoint_number),
        .mult                (mult),
        .max_packet_bytes    (max_packet_bytes),
        .transfer_size_bytes (transfer_size_bytes),
        .valid               (valid)
    );

    ptd_uframe_pack u_pack (
        .counts  (counts_flat),
        .int_dw5 (int_dw5),
        .int_dw6 (int_dw6),
        .int_dw7 (int_dw7)
    );

    always_comb begin
        counts_flat = '0;
        for (int i = 0; i < PTD_UFRAMES; i++) begin
            counts_flat[i*PTD_CNT_W +: PTD_CNT_W] = rx_count[i];
        end
    end

    // bus decode
    wire        bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land on the ack edge, the one edge at which the master is sure to still hold its request
    wire        bus_wr     = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire        wr_dw0     = bus_wr && (wb_adr_i == PTD_REG_DW0);
    wire        wr_ep_hi   = bus_wr && (wb_adr_i == PTD_REG_EP_HI);
    wire        wr_buf     = bus_wr && (wb_adr_i == PTD_REG_BUF_ADDR);
    wire        wr_status  = bus_wr && (wb_adr_i == PTD_REG_STATUS);
    wire        wr_ctrl    = bus_wr && (wb_adr_i == PTD_REG_CTRL);
    wire        wr_istat   = bus_wr && (wb_adr_i == PTD_REG_IRQ_STAT);
    wire        wr_imask   = bus_wr && (wb_adr_i == PTD_REG_IRQ_MASK);
    wire [31:0] dw0_merged = apply_sel(dw0, wb_dat_i, wb_sel_i) & PTD_DW0_WMASK;
    wire [31:0] buf_merged = apply_sel(buf_cpu, wb_dat_i, wb_sel_i);
    wire [31:0] buf_offset = buf_cpu - PTD_MEM_BASE;
    wire [31:0] buf_shift  = buf_offset >> PTD_MEM_SHIFT;
    wire [PTD_ADDR_W-1:0] buf_addr = buf_shift[PTD_ADDR_W-1:0];
    wire        start_req  = wr_ctrl && wb_sel_i[0] && wb_dat_i[PTD_CTRL_START];

    // packet sizing: never more than one maximum packet nor what is left
    wire [PTD_SIZE_W-1:0] remaining = transfer_size_bytes - bytes_done;
    wire [PTD_SIZE_W-1:0] maxp_wide = {{(PTD_SIZE_W-PTD_MAXP_W){1'b0}}, max_packet_bytes};
    wire [PTD_SIZE_W-1:0] len_wide  = (remaining < maxp_wide) ? remaining : maxp_wide;
    wire [PTD_MAXP_W-1:0] next_len  = len_wide[PTD_MAXP_W-1:0];

    // completion bookkeeping
    wire [PTD_SIZE_W:0]   sum_wide  = {1'b0, bytes_done} + {{(PTD_SIZE_W-PTD_MAXP_W+1){1'b0}}, pkt_bytes};
    wire [PTD_SIZE_W-1:0] sum_done  = sum_wide[PTD_SIZE_W] ? {PTD_SIZE_W{1'b1}} : sum_wide[PTD_SIZE_W-1:0];
    wire        in_wait    = (state == PTD_ST_WAIT);
    wire        ev_fatal   = in_wait && pkt_fatal;
    wire        ev_stall   = in_wait && !pkt_fatal && pkt_stall;
    wire        ev_done    = in_wait && !pkt_fatal && !pkt_stall && pkt_done;
    wire        all_moved  = sum_done >= transfer_size_bytes;
    wire        short_pkt  = pkt_bytes < pkt_len;
    wire [PTD_MULT_W-1:0] pkt_count_inc = pkt_count + 1'b1;
    wire        mult_used  = (pkt_count_inc == mult);
    wire        ev_finish  = ev_done && all_moved;
    wire        clr_valid  = ev_fatal || ev_stall || ev_finish;
    wire        can_start  = (state == PTD_ST_IDLE) && valid && (mult != '0) && (remaining != '0);

    // interrupt sources; a new event beats a same-cycle write-one-to-clear
    wire [PTD_IRQ_W-1:0] irq_set    = {ev_fatal, ev_stall, ev_finish};
    wire [PTD_IRQ_W-1:0] irq_clr    = (wr_istat && wb_sel_i[0]) ? wb_dat_i[PTD_IRQ_W-1:0] : '0;
    wire [PTD_IRQ_W-1:0] next_istat = (irq_status & ~irq_clr) | irq_set;
    wire [PTD_IRQ_W-1:0] next_imask = wb_sel_i[0] ? wb_dat_i[PTD_IRQ_W-1:0] : irq_mask;

    // read mux
    wire [31:0] status_word = {valid, halt, {(30-PTD_SIZE_W){1'b0}}, bytes_done};
    logic [31:0] rd_data;
    always_comb begin
        unique case (wb_adr_i)
            PTD_REG_DW0:      rd_data = dw0;
            PTD_REG_EP_HI:    rd_data = {{(32-PTD_EPHI_W){1'b0}}, endpoint_high};
            PTD_REG_BUF_ADDR: rd_data = {{(32-PTD_ADDR_W){1'b0}}, buf_addr};
            PTD_REG_STATUS:   rd_data = status_word;
            PTD_REG_IRQ_STAT: rd_data = {{(32-PTD_IRQ_W){1'b0}}, irq_status};
            PTD_REG_IRQ_MASK: rd_data = {{(32-PTD_IRQ_W){1'b0}}, irq_mask};
            PTD_REG_INT_DW5:  rd_data = int_dw5;
            PTD_REG_INT_DW6:  rd_data = int_dw6;
            PTD_REG_INT_DW7:  rd_data = int_dw7;
            default:          rd_data = 32'h0000_0000;
        endcase
    end

    // sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            PTD_ST_IDLE: begin
                if (start_req && can_start) begin
                    next_state = PTD_ST_ISSUE;
                end
            end
            PTD_ST_ISSUE: begin
                next_state = PTD_ST_WAIT;
            end
            PTD_ST_WAIT: begin
                if (ev_fatal || ev_stall || ev_finish) begin
                    next_state = PTD_ST_IDLE;
                end else if (ev_done) begin
                    // stop when the multiplier is spent or the device sent short
                    next_state = (mult_used || short_pkt) ? PTD_ST_IDLE : PTD_ST_ISSUE;
                end
            end
            default: next_state = PTD_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= PTD_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // descriptor word: hardware clear wins over a same-cycle software write
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dw0 <= 32'h0000_0000;
        end else if (clr_valid) begin
            dw0 <= (wr_dw0 ? dw0_merged : dw0) & ~(32'h0000_0001 << PTD_VALID_BIT);
        end else if (wr_dw0) begin
            dw0 <= dw0_merged;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            endpoint_high <= '0;
            buf_cpu       <= PTD_MEM_BASE;
            irq_mask      <= '0;
        end else begin
            if (wr_ep_hi && wb_sel_i[0]) begin
                endpoint_high <= wb_dat_i[PTD_EPHI_W-1:0];
            end
            if (wr_buf) begin
                buf_cpu <= buf_merged;
            end
            if (wr_imask) begin
                irq_mask <= next_imask;
            end
        end
    end

    // status write-back; a software write to the status word rearms it unless a stall or done lands in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bytes_done <= '0;
            halt       <= 1'b0;
        end else if (ev_stall) begin
            halt <= 1'b1;
        end else if (ev_done) begin
            bytes_done <= sum_done;
        end else if (wr_status) begin
            bytes_done <= '0;
            halt       <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < PTD_UFRAMES; i++) begin
                rx_count[i] <= '0;
            end
        end else if (ev_done) begin
            rx_count[pkt_uframe] <= {{(PTD_CNT_W-PTD_MAXP_W){1'b0}}, pkt_bytes};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pkt_count <= '0;
        end else if (state == PTD_ST_IDLE) begin
            pkt_count <= '0;
        end else if (ev_done) begin
            pkt_count <= pkt_count_inc;
        end
    end

    // packet request outputs, registered
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pkt_req      <= 1'b0;
            pkt_len      <= '0;
            pkt_endpoint <= '0;
            pkt_buf_addr <= '0;
            pkt_offset   <= '0;
            busy         <= 1'b0;
        end else begin
            // raised from the issue state so the request appears together with its freshly loaded fields
            pkt_req <= (state == PTD_ST_ISSUE);
            busy    <= (next_state != PTD_ST_IDLE);
            if (state == PTD_ST_ISSUE) begin
                pkt_len      <= next_len;
                pkt_endpoint <= endpoint_number;
                pkt_buf_addr <= buf_addr;
                pkt_offset   <= bytes_done;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_istat;
            irq        <= |(next_istat & (wr_imask ? next_imask : irq_mask));
        end
    end

    // classic wishbone: one wait state, ack dropped the cycle after
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end
endmodule // ptd_engine
`default_nettype wire

// ===== verilog/ptd_field_decode.sv
/*
 * ptd_field_decode: splits the first descriptor doubleword into its fields.
 * Assumes the word comes from a register on the same clock; purely combinational.
 */
`default_nettype none
module ptd_field_decode
    import ptd_pkg::*;
(
    input  wire logic [31:0]             dw0,
    input  wire logic [PTD_EPHI_W-1:0]   endpoint_high,
    output logic      [PTD_EP_W-1:0]     endpoint_number,
    output logic      [PTD_MULT_W-1:0]   mult,
    output logic      [PTD_MAXP_W-1:0]   max_packet_bytes,
    output logic      [PTD_SIZE_W-1:0]   transfer_size_bytes,
    output logic                         valid
);
    // lowest endpoint bit lives in the first word, the rest in the second
    assign endpoint_number     = {endpoint_high, dw0[PTD_EP0_BIT]};
    assign mult                = dw0[PTD_MULT_HI:PTD_MULT_LO];
    assign max_packet_bytes    = dw0[PTD_MAXP_HI:PTD_MAXP_LO];
    assign transfer_size_bytes = dw0[PTD_SIZE_HI:PTD_SIZE_LO];
    assign valid               = dw0[PTD_VALID_BIT];
    // bits 2 to 1 are simply not looked at
endmodule // ptd_field_decode
`default_nettype wire

// ===== verilog/ptd_pkg.sv
/*
 * ptd_pkg: field layout of the periodic transfer descriptor, register map,
 * interrupt bits and state codes shared by the descriptor block.
 * Assumes a single 25 MHz system clock and a 32-bit classic Wishbone slave.
 */
`default_nettype none
package ptd_pkg;
    // first doubleword field positions
    localparam int PTD_EP0_BIT     = 31;
    localparam int PTD_MULT_HI     = 30;
    localparam int PTD_MULT_LO     = 29;
    localparam int PTD_MAXP_HI     = 28;
    localparam int PTD_MAXP_LO     = 18;
    localparam int PTD_SIZE_HI     = 17;
    localparam int PTD_SIZE_LO     = 3;
    localparam int PTD_VALID_BIT   = 0;
    localparam logic [31:0] PTD_DW0_WMASK = 32'hFFFF_FFF9;

    localparam int PTD_MULT_W      = 2;
    localparam int PTD_MAXP_W      = 11;
    localparam int PTD_SIZE_W      = 15;
    localparam int PTD_EPHI_W      = 3;
    localparam int PTD_EP_W        = 4;
    localparam int PTD_CNT_W       = 12;
    localparam int PTD_UFRAMES     = 8;
    localparam int PTD_UF_W        = 3;
    localparam int PTD_ADDR_W      = 16;

    // status word layout: bytes done low, halt and active on top
    localparam int PTD_HALT_BIT    = 30;
    localparam int PTD_ACTIVE_BIT  = 31;

    // cpu to internal memory address conversion
    localparam logic [31:0] PTD_MEM_BASE  = 32'h0000_0400;
    localparam int          PTD_MEM_SHIFT = 3;

    // register byte offsets
    localparam logic [7:0] PTD_REG_DW0      = 8'h00;
    localparam logic [7:0] PTD_REG_EP_HI    = 8'h04;
    localparam logic [7:0] PTD_REG_BUF_ADDR = 8'h08;
    localparam logic [7:0] PTD_REG_STATUS   = 8'h0C;
    localparam logic [7:0] PTD_REG_CTRL     = 8'h10;
    localparam logic [7:0] PTD_REG_IRQ_STAT = 8'h14;
    localparam logic [7:0] PTD_REG_IRQ_MASK = 8'h18;
    localparam logic [7:0] PTD_REG_INT_DW5  = 8'h1C;
    localparam logic [7:0] PTD_REG_INT_DW6  = 8'h20;
    localparam logic [7:0] PTD_REG_INT_DW7  = 8'h24;

    localparam int PTD_CTRL_START  = 0;

    // interrupt bits
    localparam int PTD_IRQ_W       = 3;
    localparam int PTD_IRQ_DONE    = 0;
    localparam int PTD_IRQ_HALT    = 1;
    localparam int PTD_IRQ_FATAL   = 2;

    typedef enum logic [1:0] {
        PTD_ST_IDLE  = 2'b00,
        PTD_ST_ISSUE = 2'b01,
        PTD_ST_WAIT  = 2'b10
    } ptd_state_t;
endpackage : ptd_pkg
`default_nettype wire

// ===== verilog/ptd_uframe_pack.sv
/*
 * ptd_uframe_pack: packs eight per-microframe received-byte counts into the
 * three interrupt descriptor words they span.
 * Assumes counts are registers on the same clock; purely combinational.
 */
`default_nettype none
module ptd_uframe_pack
    import ptd_pkg::*;
(
    input  wire logic [PTD_UFRAMES*PTD_CNT_W-1:0] counts,
    output logic      [31:0]                      int_dw5,
    output logic      [31:0]                      int_dw6,
    output logic      [31:0]                      int_dw7
);
    // counts run contiguously from the bottom of word five upward,
    // so count 2 and count 5 straddle a word boundary
    assign int_dw5 = counts[31:0];
    assign int_dw6 = counts[63:32];
    assign int_dw7 = counts[95:64];
endmodule // ptd_uframe_pack
`default_nettype wire
